//--- hw/rcr_main_config_regs.sv
// Contract
// - power/mode bit 7 high selects standby, low selects active mode
// - power/mode bit 6 high selects direct mode, low selects automatic framing unless the protocol code is reserved
// - power/mode bit 5 turns transmitter and receivers on
// - power/mode bit 4 high selects half output power, low full
// - power/mode bit 3 high selects aux receive input, low main input
// - power/mode bit 1 forces receiver and oscillator on, else follow bit 5
// - chip-enable low or power-on reset loads protocol register with 0x02
// - protocol bit 7 high means no response CRC, low means check CRC
// - protocol bit 6 picks direct mode type, applied on direct entry
// - codes 0 to 7 select vicinity coding, rate and subcarrier
// - codes 8 to 11 select proximity type A at four rates
// - codes 12 to 15 select proximity type B at four rates
// - each protocol register write reloads option register defaults, except writes made while defaults are held
`timescale 1ns/1ns
module rcr_main_config_regs (
  input  wire logic            clock,          // 10 MHz system clock
  input  wire logic            rst,            // synchronous, active high
  input  wire logic            chip_enable,    // enable pin, low loads defaults
  input  wire logic            power_on_reset, // por pin, high loads defaults
  input  wire rcr_pkg::rcr_req_t host_req,     // host register request
  output logic [7:0]           host_rdata,     // read data
  output logic                 host_rvalid,    // read data valid pulse
  output logic                 option_reload,  // pulse: reload option defaults
  output rcr_pkg::rcr_cfg_t    cfg             // decoded configuration
);

  // pin synchronisers
  logic ce_s1_q;
  logic ce_s2_q;
  logic por_s1_q;
  logic por_s2_q;
  logic hold_defaults;

  always_ff @(posedge clock) begin
    if (rst) begin
      ce_s1_q  <= rcr_pkg::SYNC_CE_RST;
      ce_s2_q  <= rcr_pkg::SYNC_CE_RST;
      por_s1_q <= rcr_pkg::SYNC_POR_RST;
      por_s2_q <= rcr_pkg::SYNC_POR_RST;
    end else begin
      ce_s1_q  <= chip_enable;
      ce_s2_q  <= ce_s1_q;
      por_s1_q <= power_on_reset;
      por_s2_q <= por_s1_q;
    end
  end

  assign hold_defaults = !ce_s2_q || por_s2_q;

  // register state
  logic [7:0]        pmc_q;
  logic [7:0]        pmc_d;
  logic [7:0]        aps_q;
  logic [7:0]        aps_d;
  logic [7:0]        rdata_q;
  logic [7:0]        rdata_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic              reload_q;
  logic              reload_d;
  rcr_pkg::rcr_cfg_t cfg_q;
  rcr_pkg::rcr_cfg_t cfg_d;
  logic              wr_pmc;
  logic              wr_aps;
  logic [4:0]        code;

  assign wr_pmc = host_req.wr && (host_req.addr == rcr_pkg::POWER_AND_MODE_CONTROL_OFS);
  assign wr_aps = host_req.wr && (host_req.addr == rcr_pkg::AIR_PROTOCOL_SELECT_OFS);

  // register writes, reads and defaults
  always_comb begin
    pmc_d    = pmc_q;
    aps_d    = aps_q;
    reload_d = 1'b0;
    rvalid_d = host_req.rd;
    rdata_d  = rdata_q;
    if (hold_defaults) begin
      pmc_d = rcr_pkg::POWER_AND_MODE_CONTROL_RST;
      aps_d = rcr_pkg::AIR_PROTOCOL_SELECT_RST;
    end else begin
      if (wr_pmc) begin
        pmc_d = host_req.wdata & rcr_pkg::POWER_AND_MODE_CONTROL_WMASK;
      end
      if (wr_aps) begin
        aps_d    = host_req.wdata & rcr_pkg::AIR_PROTOCOL_SELECT_WMASK;
        reload_d = 1'b1;
      end
    end
    if (host_req.rd) begin
      unique case (host_req.addr)
        rcr_pkg::POWER_AND_MODE_CONTROL_OFS: rdata_d = pmc_q;
        rcr_pkg::AIR_PROTOCOL_SELECT_OFS:    rdata_d = aps_q;
        default:                             rdata_d = rcr_pkg::UNMAPPED_READ_VALUE;
      endcase
    end
  end

  assign code = aps_d[rcr_pkg::APS_CODE_MSB:rcr_pkg::APS_CODE_LSB];

  // decode next register values into front-end controls
  always_comb begin
    cfg_d                       = cfg_q;
    cfg_d.standby               = pmc_d[rcr_pkg::PMC_STANDBY_BIT];
    cfg_d.direct_mode           = pmc_d[rcr_pkg::PMC_DIRECT_BIT];
    // type is taken when direct mode is entered; host sets it first
    if (pmc_d[rcr_pkg::PMC_DIRECT_BIT] && !cfg_q.direct_mode) begin
      cfg_d.direct_type = aps_d[rcr_pkg::APS_DIR_TYPE_BIT];
    end
    cfg_d.carrier_output_enable = pmc_d[rcr_pkg::PMC_CARRIER_BIT];
    cfg_d.half_power_select     = pmc_d[rcr_pkg::PMC_HALF_PWR_BIT];
    cfg_d.receive_input_select  = pmc_d[rcr_pkg::PMC_RX_INPUT_BIT];
    cfg_d.receiver_enable       = pmc_d[rcr_pkg::PMC_RX_FORCE_BIT]
                                  || pmc_d[rcr_pkg::PMC_CARRIER_BIT];
    cfg_d.tx_osc_enable         = pmc_d[rcr_pkg::PMC_RX_FORCE_BIT]
                                  || pmc_d[rcr_pkg::PMC_CARRIER_BIT];
    cfg_d.supply_range_select   = pmc_d[rcr_pkg::PMC_SUPPLY_BIT];
    cfg_d.rx_crc_check          = !aps_d[rcr_pkg::APS_NO_CRC_BIT];
    // protocol code decode
    cfg_d.vicinity       = (code < rcr_pkg::CODE_PROX_A_FIRST);
    cfg_d.vic_one_of_256 = code[0];
    cfg_d.vic_high_rate  = code[1];
    cfg_d.vic_double_sub = code[2];
    cfg_d.prox_a         = (code >= rcr_pkg::CODE_PROX_A_FIRST)
                           && (code < rcr_pkg::CODE_PROX_B_FIRST);
    cfg_d.prox_b         = (code >= rcr_pkg::CODE_PROX_B_FIRST)
                           && (code[4] == 1'b0);
    cfg_d.smart_card     = (code == rcr_pkg::CODE_CARD_212)
                           || (code == rcr_pkg::CODE_CARD_424);
    cfg_d.rate_sel       = code[1:0];
    // rfid bit set also counts as reserved
    cfg_d.reserved_code  = !(cfg_d.vicinity || cfg_d.prox_a || cfg_d.prox_b
                           || cfg_d.smart_card)
                           || aps_d[rcr_pkg::APS_RFID_BIT];
    cfg_d.auto_framing   = !pmc_d[rcr_pkg::PMC_DIRECT_BIT]
                           && !cfg_d.reserved_code;
  end

  // state registers
  always_ff @(posedge clock) begin
    if (rst) begin
      pmc_q    <= rcr_pkg::POWER_AND_MODE_CONTROL_RST;
      aps_q    <= rcr_pkg::AIR_PROTOCOL_SELECT_RST;
      rdata_q  <= rcr_pkg::UNMAPPED_READ_VALUE;
      rvalid_q <= 1'b0;
      reload_q <= 1'b0;
      cfg_q    <= rcr_pkg::CFG_RST;
    end else begin
      pmc_q    <= pmc_d;
      aps_q    <= aps_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      reload_q <= reload_d;
      cfg_q    <= cfg_d;
    end
  end

  assign host_rdata    = rdata_q;
  assign host_rvalid   = rvalid_q;
  assign option_reload = reload_q;
  assign cfg           = cfg_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_defaults;
    hold_defaults |=> (pmc_q == rcr_pkg::POWER_AND_MODE_CONTROL_RST)
                      && (aps_q == rcr_pkg::AIR_PROTOCOL_SELECT_RST);
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not loaded");

  property p_standby;
    (wr_pmc && !hold_defaults) |=> cfg_q.standby == $past(host_req.wdata[7]);
  endproperty
  a_standby: assert property (p_standby) else $error("standby not from write");

  property p_auto_framing;
    cfg_q.direct_mode |-> !cfg_q.auto_framing;
  endproperty
  a_auto_framing: assert property (p_auto_framing) else $error("framing in direct");

  property p_carrier;
    cfg_q.carrier_output_enable == pmc_q[5];
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier mismatch");

  property p_half_power;
    (wr_pmc && !hold_defaults) |=> cfg_q.half_power_select == $past(host_req.wdata[4]);
  endproperty
  a_half_power: assert property (p_half_power) else $error("power not from write");

  property p_rx_input;
    cfg_q.receive_input_select == pmc_q[3];
  endproperty
  a_rx_input: assert property (p_rx_input) else $error("rx input mismatch");

  property p_rx_enable;
    cfg_q.receiver_enable == (pmc_q[1] || pmc_q[5]);
  endproperty
  a_rx_enable: assert property (p_rx_enable) else $error("receiver enable wrong");

  property p_supply;
    cfg_q.supply_range_select == pmc_q[0];
  endproperty
  a_supply: assert property (p_supply) else $error("supply range mismatch");

  property p_crc;
    cfg_q.rx_crc_check != aps_q[7];
  endproperty
  a_crc: assert property (p_crc) else $error("crc check wrong");

  property p_dir_type;
    $rose(cfg_q.direct_mode) |-> cfg_q.direct_type == aps_q[6];
  endproperty
  a_dir_type: assert property (p_dir_type) else $error("direct type not taken");

  property p_vicinity;
    cfg_q.vicinity == (aps_q[4:3] == 2'b00);
  endproperty
  a_vicinity: assert property (p_vicinity) else $error("vicinity decode wrong");

  property p_prox;
    (cfg_q.prox_a == (aps_q[4:2] == 3'b010)) && (cfg_q.prox_b == (aps_q[4:2] == 3'b011));
  endproperty
  a_prox: assert property (p_prox) else $error("proximity decode wrong");

  property p_card;
    cfg_q.smart_card |-> (aps_q[4:1] == 4'hD) && (cfg_q.rate_sel[1] == 1'b1);
  endproperty
  a_card: assert property (p_card) else $error("card decode wrong");

  property p_reload;
    (wr_aps && !hold_defaults) |=> option_reload;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload pulse");

  property p_reload_cause;
    option_reload |-> $past(wr_aps) && !$past(hold_defaults);
  endproperty
  a_reload_cause: assert property (p_reload_cause) else $error("stray reload");

  property p_reserved;
    (aps_q[4:0] == 5'h10) |-> cfg_q.reserved_code && !cfg_q.auto_framing;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved not flagged");

endmodule

//--- hw/rcr_pkg.sv
package rcr_pkg;

  // register offsets on the host port
  localparam logic [4:0] POWER_AND_MODE_CONTROL_OFS = 5'h00;
  localparam logic [4:0] AIR_PROTOCOL_SELECT_OFS    = 5'h01;

  // values after chip-enable low or power-on reset
  localparam logic [7:0] POWER_AND_MODE_CONTROL_RST = 8'h01;
  localparam logic [7:0] AIR_PROTOCOL_SELECT_RST    = 8'h02;

  // writable bits; the reserved bit reads as zero
  localparam logic [7:0] POWER_AND_MODE_CONTROL_WMASK = 8'hFB;
  localparam logic [7:0] AIR_PROTOCOL_SELECT_WMASK    = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ_VALUE          = 8'h00;

  // power_and_mode_control field positions
  localparam int PMC_STANDBY_BIT = 7;
  localparam int PMC_DIRECT_BIT  = 6;
  localparam int PMC_CARRIER_BIT = 5;
  localparam int PMC_HALF_PWR_BIT = 4;
  localparam int PMC_RX_INPUT_BIT = 3;
  localparam int PMC_RX_FORCE_BIT = 1;
  localparam int PMC_SUPPLY_BIT  = 0;

  // air_protocol_select field positions
  localparam int APS_NO_CRC_BIT   = 7;
  localparam int APS_DIR_TYPE_BIT = 6;
  localparam int APS_RFID_BIT     = 5;
  localparam int APS_CODE_MSB     = 4;
  localparam int APS_CODE_LSB     = 0;

  // protocol code ranges
  localparam logic [4:0] CODE_PROX_A_FIRST  = 5'h08;
  localparam logic [4:0] CODE_PROX_B_FIRST  = 5'h0C;
  localparam logic [4:0] CODE_CARD_212      = 5'h1A;
  localparam logic [4:0] CODE_CARD_424      = 5'h1B;

  // synchroniser values forced while rst is high
  localparam logic SYNC_CE_RST  = 1'b0;
  localparam logic SYNC_POR_RST = 1'b1;

  // host request toward the register pair
  typedef struct packed {
    logic       wr;    // write strobe
    logic       rd;    // read strobe
    logic [4:0] addr;  // register offset
    logic [7:0] wdata; // write data
  } rcr_req_t;

  // decoded front-end configuration
  typedef struct packed {
    logic       standby;          // regulators and oscillator only
    logic       direct_mode;      // raw or custom framing
    logic       direct_type;      // direct mode 0 or 1, taken at entry
    logic       auto_framing;     // built-in decoders in use
    logic       carrier_output_enable;
    logic       half_power_select;
    logic       receive_input_select;
    logic       receiver_enable;
    logic       tx_osc_enable;
    logic       supply_range_select;
    logic       rx_crc_check;
    logic       vicinity;
    logic       vic_one_of_256;
    logic       vic_high_rate;
    logic       vic_double_sub;
    logic       prox_a;
    logic       prox_b;
    logic       smart_card;
    logic       reserved_code;
    logic [1:0] rate_sel;         // 106/212/424/848 for prox, 212/424 for card
  } rcr_cfg_t;

  // decoded configuration of the reset values, so cfg agrees with the registers
  localparam rcr_cfg_t CFG_RST = '{
    standby: 1'b0, direct_mode: 1'b0, direct_type: 1'b0, auto_framing: 1'b1,
    carrier_output_enable: 1'b0, half_power_select: 1'b0, receive_input_select: 1'b0,
    receiver_enable: 1'b0, tx_osc_enable: 1'b0, supply_range_select: 1'b1,
    rx_crc_check: 1'b1, vicinity: 1'b1, vic_one_of_256: 1'b0, vic_high_rate: 1'b1,
    vic_double_sub: 1'b0, prox_a: 1'b0, prox_b: 1'b0, smart_card: 1'b0,
    reserved_code: 1'b0, rate_sel: 2'h2
  };

endpackage

//--- tb/rcr_host_model.sv
`timescale 1ns/1ns
module rcr_host_model (
  input  wire logic         clock, // system clock
  output rcr_pkg::rcr_req_t req    // request toward the register pair
);
  // one request, held from a falling edge across the next rising edge
  task automatic access(input logic w, input logic r, input logic [4:0] a,
                        input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == rcr_pkg::AIR_PROTOCOL_SELECT_OFS) begin
      v[rcr_pkg::APS_RFID_BIT] = 1'b0;
    end
    req = '{w, r, a, v};
    @(negedge clock);
  endtask
  // released bus shows the inverse of the last address and data
  task automatic idle();
    req = '{1'b0, 1'b0, ~req.addr, ~req.wdata};
    @(negedge clock);
  endtask
  initial req = '0;
endmodule

//--- tb/rcr_main_config_regs_test.sv
`timescale 1ns/1ns
module rcr_main_config_regs_test;
  logic              clock;
  logic              rst;
  logic              chip_enable;
  logic              power_on_reset;
  rcr_pkg::rcr_req_t host_req;
  logic [7:0]        host_rdata;
  logic              host_rvalid;
  logic              option_reload;
  rcr_pkg::rcr_cfg_t cfg;
  logic [7:0]        pmc_m;
  logic [7:0]        aps_m;
  logic [7:0]        rnd;
  logic [7:0]        q[$];
  logic              dt_m;
  int                miscompares;
  int                comparisons;
  int                reloads;
  int                exp_reloads;
  int                i;

  rcr_main_config_regs rcr_main_config_regs_inst (
    .clock(clock), .rst(rst), .chip_enable(chip_enable), .power_on_reset(power_on_reset),
    .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .option_reload(option_reload), .cfg(cfg));
  rcr_host_model rcr_host_model_inst (.clock(clock), .req(host_req));

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp_val(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_cfg(input rcr_pkg::rcr_cfg_t e);
    comparisons++;
    if (cfg !== e) begin
      miscompares++;
      $display("[FAIL] cfg expected %h seen %h", e, cfg);
    end
  endtask

  // expected decode of both registers
  function automatic rcr_pkg::rcr_cfg_t exp_cfg(input logic [7:0] p, input logic [7:0] a,
                                                input logic d);
    logic [4:0] k;
    logic       v;
    logic       pa;
    logic       pb;
    logic       sc;
    logic       rs;
    k = a[4:0];
    v = (k < 5'h08);
    pa = (k[4:2] == 3'h2);
    pb = (k[4:2] == 3'h3);
    sc = (k[4:1] == 4'hD);
    rs = !(v | pa | pb | sc) | a[5];
    return '{p[7], p[6], d, !p[6] && !rs, p[5], p[4], p[3], p[1] | p[5], p[1] | p[5],
             p[0], !a[7], v, k[0], k[1], k[2], pa, pb, sc, rs, k[1:0]};
  endfunction

  // write with mirror update and decode check
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    if (a == 5'h00) begin
      if (d[6] && !pmc_m[6]) dt_m = aps_m[6];
      pmc_m = d & rcr_pkg::POWER_AND_MODE_CONTROL_WMASK;
    end else begin
      aps_m = {d[7:6], 1'b0, d[4:0]};
      exp_reloads++;
    end
    rcr_host_model_inst.access(1'b1, 1'b0, a, d);
    cmp_cfg(exp_cfg(pmc_m, aps_m, dt_m));
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    q.push_back(e);
    rcr_host_model_inst.access(1'b0, 1'b1, a, 8'h00);
  endtask

  // result watcher: read data against oldest note, reload pulses counted
  always @(negedge clock) begin
    if (host_rvalid === 1'b1) begin
      if (q.size() == 0) cmp_val("host_rvalid", 32'h0, 32'h1);
      else cmp_val("host_rdata", {24'h0, q.pop_front()}, {24'h0, host_rdata});
    end
    if (option_reload === 1'b1) reloads++;
  end

  // hang guard
  initial begin
    #2000000;
    miscompares++;
    $display("[FAIL] run time expected end seen limit");
    final_report();
  end

  initial begin
    rst = 1'b1;
    chip_enable = 1'b1;
    power_on_reset = 1'b0;
    {miscompares, comparisons, reloads, exp_reloads} = '0;
    pmc_m = 8'h01;
    aps_m = 8'h02;
    dt_m = 1'b0;
    rnd = 8'($urandom(44));
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    cmp_cfg(exp_cfg(pmc_m, aps_m, dt_m));
    rd(5'h00, 8'h01);
    rd(5'h01, 8'h02);
    // random power and mode settings, direct bit kept clear
    for (i = 0; i < 12; i++) begin
      rnd = 8'($urandom);
      wr(5'h00, rnd & 8'hBF);
      rd(5'h00, pmc_m);
    end
    // every protocol code, back to back
    for (i = 0; i < 32; i++) begin
      rnd = 8'($urandom);
      wr(5'h01, {rnd[7:5], i[4:0]});
    end
    rd(5'h01, aps_m);
    // unmapped place: write ignored, read gives zero
    rcr_host_model_inst.access(1'b1, 1'b0, 5'h03, 8'hFF);
    rd(5'h03, rcr_pkg::UNMAPPED_READ_VALUE);
    rd(5'h00, pmc_m);
    // direct mode: type bit written first, latched on entry only
    wr(5'h01, 8'h42);
    wr(5'h00, 8'h40);
    wr(5'h01, 8'h02);
    wr(5'h00, 8'h00);
    wr(5'h00, 8'h40);
    wr(5'h00, 8'h00);
    // defaults forced by chip-enable low, then by power-on reset
    for (i = 0; i < 2; i++) begin
      wr(5'h00, 8'hB2);
      wr(5'h01, 8'h8C);
      rcr_host_model_inst.idle();
      if (i == 0) chip_enable = 1'b0;
      else power_on_reset = 1'b1;
      repeat (3) @(negedge clock);
      rcr_host_model_inst.access(1'b1, 1'b0, 5'h00, 8'hFF);
      pmc_m = 8'h01;
      aps_m = 8'h02;
      rd(5'h00, 8'h01);
      rd(5'h01, 8'h02);
      cmp_cfg(exp_cfg(pmc_m, aps_m, dt_m));
      rcr_host_model_inst.idle();
      chip_enable = 1'b1;
      power_on_reset = 1'b0;
      repeat (4) @(negedge clock);
    end
    rcr_host_model_inst.idle();
    cmp_val("option_reload", 32'(exp_reloads), 32'(reloads));
    for (i = 0; i < 10 && q.size() != 0; i++) @(negedge clock);
    if (q.size() != 0) begin
      miscompares++;
      $display("[FAIL] host_rvalid expected %0d more seen none", q.size());
    end
    final_report();
  end
endmodule
